// >>> bench/aicsp_pin_model.sv
`timescale 1ns/1ps

module aicsp_pin_model
  import aicsp_pkg::*;
(
  // design drive and far-side drive
  input  wire aicsp_pin_drv_t drv_i,
  input  wire logic [4:0]     ext_i,
  // resolved pin levels
  output logic      [4:0]     pin_o
);
  // a driving design pin wins, else the far side drives the wire
  always_comb
  begin
    for (int i = 0; i < 5; i++)
      pin_o[i] = drv_i.oe_n[i] ? ext_i[i] : drv_i.out[i];
  end
endmodule

// >>> bench/analog_input_and_chip_select_ports_tb.sv
`timescale 1ns/1ps
`include "aicsp_consts.svh"

module analog_input_and_chip_select_ports_tb
  import aicsp_pkg::*;
;
  localparam logic [17:0] A_AN  = {`AICSP_IDX_ANALOG, 2'b00};
  localparam logic [17:0] A_DIR = {`AICSP_IDX_DIRECTION, 2'b00};
  localparam logic [17:0] A_DAT = {`AICSP_IDX_OUT_DATA, 2'b00};
  logic           clk = 0;
  logic           rst = 1;
  logic [17:0]    adr = 0;
  logic           rd = 0;
  logic           wr = 0;
  logic [31:0]    wd = 0;
  logic [3:0]     be = 1;
  logic [31:0]    rdat;
  logic           wait_o;
  logic [2:0]     mode = 2;
  logic           hws = 0;
  logic           sws = 0;
  logic           rfe = 0;
  logic           rfs = 0;
  logic [3:0]     cs = 4'h5;
  logic [3:0]     ien = 0;
  logic [7:0]     an = 0;
  logic [4:0]     ext = 5'h0b;
  logic [4:0]     pin;
  aicsp_pin_drv_t drv;
  logic [3:0]     irq_n;
  logic [31:0]    exp_q[$];
  logic [7:0]     d;
  logic [4:0]     dir;
  logic [4:0]     pv;
  int             seed = 73;
  int             fails = 0;
  int             n_checks = 0;
  int             cyc = 0;

  aicsp_ports uut (.core_clk_i(clk), .sys_rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_o), .mode_i(mode), .hw_standby_i(hws), .sw_standby_i(sws),
    .refresh_enable_bit_i(rfe), .refresh_strobe_i(rfs), .chip_select_i(cs),
    .interrupt_enable_settings_i(ien), .analog_pin_i(an), .select_pin_i(pin),
    .select_pin_drv_o(drv), .external_interrupt_n_o(irq_n));

  aicsp_pin_model pins (.drv_i(drv), .ext_i(ext), .pin_o(pin));

  // 125 MHz clock
  always #4 clk = ~clk;

  task automatic end_sim;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // hold the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] v);
    adr <= a;
    wd <= {24'h0, v};
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wait_o !== 1'b0);
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask

  task automatic rd_exp(input logic [17:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(0, a, 8'h00);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  // compare driven pins, undriven out bits masked
  task automatic pchk(input logic [4:0] o, input logic [4:0] oen);
    chk({22'h0, drv.out & ~drv.oe_n, drv.oe_n}, {22'h0, o, oen});
  endtask

  task automatic do_reset(input logic [2:0] m);
    mode <= m;
    rst <= 1;
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    settle;
  endtask

  // read data taken at the acknowledge edge against the oldest note
  always @(posedge clk)
  begin
    if (rd && wait_o === 1'b0)
      chk(rdat, exp_q.pop_front());
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      end_sim;
    end
  end

  initial
  begin
    do_reset(3'd2);
    pchk({cs[0], 4'h0}, 5'h0f);
    rd_exp(A_DIR, 8'hff);
    rd_exp(A_DAT, {4'he, ext[3:0]});
    do_reset(3'd5);
    pchk(5'h00, 5'h1f);
    // analog pins read back, writes and stray addresses ignored
    repeat (3)
    begin
      an <= $random(seed);
      @(posedge clk);
      bus(1, A_AN, ~an);
      rd_exp(A_AN, an);
    end
    bus(1, 18'h00010, 8'hff);
    rd_exp(18'h00010, 8'h00);
    d = $random(seed);
    bus(1, A_DIR, 8'h1f);
    bus(1, A_DAT, d);
    settle;
    pchk({cs[0], cs[1], cs[2], cs[3], d[0]}, 5'h00);
    rfe <= 1;
    rfs <= 1;
    settle;
    pchk({cs[0], cs[1], cs[2], cs[3], 1'b1}, 5'h00);
    bus(1, A_DIR, 8'h00);
    settle;
    pchk(5'h01, 5'h1e);
    rd_exp(A_DAT, {3'h7, ext[4:1], 1'b1});
    do_reset(3'd7);
    pchk(5'h00, 5'h1f);
    // single-chip random direction, data and interrupt enables
    repeat (4)
    begin
      dir = $random(seed);
      d = $random(seed);
      ien <= $random(seed);
      ext <= $random(seed);
      bus(1, A_DIR, {3'h0, dir});
      bus(1, A_DAT, d);
      settle;
      pv = (d[4:0] & dir) | (ext & ~dir);
      pchk(d[4:0] & dir, ~dir);
      chk({28'h0, irq_n}, {28'h0, pv[3:0] | ~ien});
      rd_exp(A_DAT, {3'h7, pv});
    end
    be <= 0;
    bus(1, A_DAT, ~d);
    be <= 1;
    rd_exp(A_DAT, {3'h7, pv});
    bus(1, A_DIR, 8'h1f);
    settle;
    sws <= 1;
    bus(1, A_DAT, ~d);
    settle;
    pchk(d[4:0], 5'h00);
    sws <= 0;
    settle;
    pchk(~d[4:0], 5'h00);
    hws <= 1;
    settle;
    hws <= 0;
    settle;
    pchk(5'h00, 5'h1f);
    rd_exp(A_DAT, {3'h7, ext});
    settle;
    end_sim;
  end
endmodule

// >>> src/aicsp_consts.svh
`ifndef AICSP_CONSTS_SVH
`define AICSP_CONSTS_SVH

// register indices; byte address is four times the index
`define AICSP_IDX_ANALOG     16'hffce
`define AICSP_IDX_DIRECTION  16'hffcd
`define AICSP_IDX_OUT_DATA   16'hffcf

// bus and register widths
`define AICSP_ADDR_W         18
`define AICSP_PORT_W         5

// reset values of the select port registers
`define AICSP_DIR_RST_ROMLESS 8'hf0
`define AICSP_DIR_RST_OTHER   8'he0
`define AICSP_DATA_RST        8'he0

// read-back constants
`define AICSP_DIR_READ        8'hff
`define AICSP_DATA_RSVD       3'h7

// pin positions
`define AICSP_PIN_REFRESH     0
`define AICSP_PIN_CS0         4

`endif

// >>> src/aicsp_pkg.sv
package aicsp_pkg;

  // class of operating mode
  typedef enum logic [1:0]
  {
    AICSP_MODE_ROMLESS = 2'b00,
    AICSP_MODE_ROM_EXP = 2'b01,
    AICSP_MODE_SINGLE  = 2'b10
  } aicsp_mode_t;

  // bus answer phase
  typedef enum logic
  {
    AICSP_BUS_IDLE = 1'b0,
    AICSP_BUS_ACK  = 1'b1
  } aicsp_bus_t;

  // drive of the five select port pins
  typedef struct packed
  {
    logic [4:0] out;
    logic [4:0] oe_n;
  } aicsp_pin_drv_t;

endpackage

// >>> src/aicsp_ports.sv
`timescale 1ns/1ps
`include "aicsp_consts.svh"

module aicsp_ports
  import aicsp_pkg::*;
(
  // clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     sys_rst_i,
  // avalon-mm slave
  input  wire logic [`AICSP_ADDR_W-1:0] avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [31:0]              avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic      [31:0]              avs_readdata_o,
  output logic                          avs_waitrequest_o,
  // chip state
  input  wire logic [2:0]               mode_i,
  input  wire logic                     hw_standby_i,
  input  wire logic                     sw_standby_i,
  // alternate function sources
  input  wire logic                     refresh_enable_bit_i,
  input  wire logic                     refresh_strobe_i,
  input  wire logic [3:0]               chip_select_i,
  input  wire logic [3:0]               interrupt_enable_settings_i,
  // pins
  input  wire logic [7:0]               analog_pin_i,
  input  wire logic [4:0]               select_pin_i,
  output aicsp_pin_drv_t                select_pin_drv_o,
  // interrupt requests, active low
  output logic [3:0]                    external_interrupt_n_o
);

  logic [4:0]      select_port_direction_reg;
  logic [4:0]      select_port_output_data_reg;
  aicsp_bus_t      bus_state_reg;
  aicsp_mode_t     mode_class;
  logic            expanded;
  logic            init;
  aicsp_pin_drv_t  drv_next;
  logic [7:0]      read_next;

  // init values, cut to the five stored bits on purpose
  localparam logic [7:0] DIR_INIT_ROMLESS = `AICSP_DIR_RST_ROMLESS;
  localparam logic [7:0] DIR_INIT_OTHER   = `AICSP_DIR_RST_OTHER;
  localparam logic [7:0] DATA_INIT        = `AICSP_DATA_RST;

  // index match on a word-aligned byte address
  function automatic logic addr_hit(input logic [`AICSP_ADDR_W-1:0] addr,
                                    input logic [15:0] idx);
    addr_hit = (addr == {idx, 2'b00});
  endfunction

  // mode decode: 1..4 romless, 5..6 rom expanded, else single chip
  always_comb
  begin
    if (mode_i >= 3'h1 && mode_i <= 3'h4)
      mode_class = AICSP_MODE_ROMLESS;
    else if (mode_i == 3'h5 || mode_i == 3'h6)
      mode_class = AICSP_MODE_ROM_EXP;
    else
      mode_class = AICSP_MODE_SINGLE;
  end

  assign expanded = (mode_class != AICSP_MODE_SINGLE);
  assign init     = sys_rst_i | hw_standby_i;

  // bus phase: one wait cycle, then one acknowledge cycle
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      bus_state_reg <= AICSP_BUS_IDLE;
    else
    begin
      case (bus_state_reg)
        AICSP_BUS_IDLE:
          if (avs_read_i | avs_write_i)
            bus_state_reg <= AICSP_BUS_ACK;
        AICSP_BUS_ACK:
          bus_state_reg <= AICSP_BUS_IDLE;
        default:
          bus_state_reg <= AICSP_BUS_IDLE;
      endcase
    end
  end

  // waitrequest low only during the acknowledge cycle
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= !((bus_state_reg == AICSP_BUS_IDLE) & (avs_read_i | avs_write_i));
  end

  // read multiplexer
  always_comb
  begin
    read_next = 8'h00;
    if (addr_hit(avs_address_i, `AICSP_IDX_ANALOG))
      read_next = analog_pin_i;
    else if (addr_hit(avs_address_i, `AICSP_IDX_DIRECTION))
      read_next = `AICSP_DIR_READ;
    else if (addr_hit(avs_address_i, `AICSP_IDX_OUT_DATA))
      read_next = {`AICSP_DATA_RSVD,
                   (select_port_direction_reg & select_port_output_data_reg) |
                   (~select_port_direction_reg & select_pin_i)};
  end

  // read data captured in the wait cycle, stands through acknowledge
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (bus_state_reg == AICSP_BUS_IDLE && avs_read_i)
      avs_readdata_o <= {24'h00_0000, read_next};
  end

  // direction register
  always_ff @(posedge core_clk_i)
  begin
    if (init)
      select_port_direction_reg <= (mode_class == AICSP_MODE_ROMLESS) ?
        DIR_INIT_ROMLESS[4:0] : DIR_INIT_OTHER[4:0];
    else if (bus_state_reg == AICSP_BUS_ACK && avs_write_i && avs_byteenable_i[0] &&
             addr_hit(avs_address_i, `AICSP_IDX_DIRECTION))
      select_port_direction_reg <= avs_writedata_i[4:0];
  end

  // output data register; bits 7 to 5 are not stored
  always_ff @(posedge core_clk_i)
  begin
    if (init)
      select_port_output_data_reg <= DATA_INIT[4:0];
    else if (bus_state_reg == AICSP_BUS_ACK && avs_write_i && avs_byteenable_i[0] &&
             addr_hit(avs_address_i, `AICSP_IDX_OUT_DATA))
      select_port_output_data_reg <= avs_writedata_i[4:0];
  end

  // pin function selection
  always_comb
  begin
    drv_next.out  = select_port_output_data_reg;
    drv_next.oe_n = ~select_port_direction_reg;
    // chip selects in reverse pin order
    if (expanded)
    begin
      for (int k = 0; k < 4; k++)
        if (select_port_direction_reg[`AICSP_PIN_CS0-k])
          drv_next.out[`AICSP_PIN_CS0-k] = chip_select_i[k];
    end
    if (expanded && refresh_enable_bit_i)
    begin
      drv_next.out[`AICSP_PIN_REFRESH]  = refresh_strobe_i;
      drv_next.oe_n[`AICSP_PIN_REFRESH] = 1'b0;
    end
  end

  // pin drive register, frozen during software standby unless hardware standby is also set
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      select_pin_drv_o <= '{out: 5'h00, oe_n: 5'h1f};
    else if (!sw_standby_i || hw_standby_i)
      select_pin_drv_o <= drv_next;
  end

  // interrupt requests pass the pin level when enabled
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      external_interrupt_n_o <= 4'hf;
    else
      external_interrupt_n_o <= select_pin_i[3:0] | ~interrupt_enable_settings_i;
  end

  // bus handshake sequences
  sequence s_req_idle;
    (bus_state_reg == AICSP_BUS_IDLE) && (avs_read_i || avs_write_i);
  endsequence

  sequence s_ack_once;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  property p_bus_answer;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    s_req_idle |=> s_ack_once;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle after request");

  property p_analog_read;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (s_req_idle and (avs_read_i && addr_hit(avs_address_i, `AICSP_IDX_ANALOG)))
      |=> avs_readdata_o == {24'h00_0000, $past(analog_pin_i)};
  endproperty
  a_analog_read: assert property (p_analog_read)
    else $error("analog read does not return pin levels");

  property p_dir_read;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (s_req_idle and (avs_read_i && addr_hit(avs_address_i, `AICSP_IDX_DIRECTION)))
      |=> avs_readdata_o == 32'h0000_00ff;
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction read not all ones");

  property p_data_rsvd;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (s_req_idle and (avs_read_i && addr_hit(avs_address_i, `AICSP_IDX_OUT_DATA)))
      |=> avs_readdata_o[7:5] == 3'h7;
  endproperty
  a_data_rsvd: assert property (p_data_rsvd)
    else $error("data bits 7 to 5 not ones");

  property p_dir_init;
    @(posedge core_clk_i)
    init |=> select_port_direction_reg == (($past(mode_class) == AICSP_MODE_ROMLESS) ? 5'h10 : 5'h00);
  endproperty
  a_dir_init: assert property (p_dir_init)
    else $error("direction init value wrong");

  property p_data_init;
    @(posedge core_clk_i)
    init |=> select_port_output_data_reg == 5'h00;
  endproperty
  a_data_init: assert property (p_data_init)
    else $error("data init value wrong");

  property p_refresh_pin;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (expanded && refresh_enable_bit_i && !sw_standby_i)
      |=> !select_pin_drv_o.oe_n[0] && select_pin_drv_o.out[0] == $past(refresh_strobe_i);
  endproperty
  a_refresh_pin: assert property (p_refresh_pin)
    else $error("pin 0 not driving refresh strobe");

  property p_cs0_pin;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (expanded && select_port_direction_reg[4] && !sw_standby_i)
      |=> !select_pin_drv_o.oe_n[4] && select_pin_drv_o.out[4] == $past(chip_select_i[0]);
  endproperty
  a_cs0_pin: assert property (p_cs0_pin)
    else $error("pin 4 not driving chip select 0");

  property p_single_chip;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!expanded && !sw_standby_i)
      |=> select_pin_drv_o.out == $past(select_port_output_data_reg) &&
          select_pin_drv_o.oe_n == ~$past(select_port_direction_reg);
  endproperty
  a_single_chip: assert property (p_single_chip)
    else $error("single-chip pin drive not general I/O");

  property p_standby_hold;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (sw_standby_i && !hw_standby_i) |=> $stable(select_pin_drv_o);
  endproperty
  a_standby_hold: assert property (p_standby_hold)
    else $error("pin drive changed in software standby");

  property p_irq_pass;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    interrupt_enable_settings_i[0] |=> external_interrupt_n_o[0] == $past(select_pin_i[0]);
  endproperty
  a_irq_pass: assert property (p_irq_pass)
    else $error("interrupt 0 not following pin");

  property p_irq_mask;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !interrupt_enable_settings_i[3] |=> external_interrupt_n_o[3];
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("masked interrupt 3 not idle high");

  property p_dir_write;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!init && bus_state_reg == AICSP_BUS_ACK && avs_write_i && avs_byteenable_i[0] &&
     addr_hit(avs_address_i, `AICSP_IDX_DIRECTION))
      |=> select_port_direction_reg == $past(avs_writedata_i[4:0]);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write not stored");

  property p_data_write;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!init && bus_state_reg == AICSP_BUS_ACK && avs_write_i && avs_byteenable_i[0] &&
     addr_hit(avs_address_i, `AICSP_IDX_OUT_DATA))
      |=> select_port_output_data_reg == $past(avs_writedata_i[4:0]);
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("data write not stored");

  property p_expanded_input;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (expanded && !select_port_direction_reg[3] && !sw_standby_i)
      |=> select_pin_drv_o.oe_n[3];
  endproperty
  a_expanded_input: assert property (p_expanded_input)
    else $error("pin 3 driven with direction 0");

  property p_gpio_pin0;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!refresh_enable_bit_i && !sw_standby_i)
      |=> select_pin_drv_o.oe_n[0] == !$past(select_port_direction_reg[0]) &&
          select_pin_drv_o.out[0] == $past(select_port_output_data_reg[0]);
  endproperty
  a_gpio_pin0: assert property (p_gpio_pin0)
    else $error("pin 0 not general I/O with refresh off");

  property p_single_no_refresh;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (!expanded && refresh_enable_bit_i && !sw_standby_i)
      |=> select_pin_drv_o.oe_n[0] == !$past(select_port_direction_reg[0]) &&
          select_pin_drv_o.out[0] == $past(select_port_output_data_reg[0]);
  endproperty
  a_single_no_refresh: assert property (p_single_no_refresh)
    else $error("refresh strobe on pin 0 in single-chip mode");

  property p_cs3_pin;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    (expanded && select_port_direction_reg[1] && !sw_standby_i)
      |=> !select_pin_drv_o.oe_n[1] && select_pin_drv_o.out[1] == $past(chip_select_i[3]);
  endproperty
  a_cs3_pin: assert property (p_cs3_pin)
    else $error("pin 1 not driving chip select 3");

  property p_romless_reset;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    ($fell(sys_rst_i) && !sw_standby_i && mode_class == AICSP_MODE_ROMLESS && $stable(mode_i))
      |=> select_pin_drv_o.oe_n[4:1] == 4'h7;
  endproperty
  a_romless_reset: assert property (p_romless_reset)
    else $error("modes 1 to 4 reset drive not chip select 0 only");

  property p_romexp_reset;
    @(posedge core_clk_i) disable iff (sys_rst_i)
    ($fell(sys_rst_i) && !sw_standby_i && mode_class == AICSP_MODE_ROM_EXP && $stable(mode_i))
      |=> select_pin_drv_o.oe_n[4:1] == 4'hf;
  endproperty
  a_romexp_reset: assert property (p_romexp_reset)
    else $error("modes 5 and 6 reset pins not all inputs");

endmodule
